// file: bench/dac_host_model.sv
// Host-side register and select driver for the converter control block.
`timescale 1ns/10ps
module dac_host_model #(parameter int CHANNELS = 4) (
    input logic clk,
    input logic [15:0] reg_rdata,
    output logic [4:0] reg_addr,
    output logic reg_wr, ref_select_wr,
    output logic [15:0] reg_wdata,
    output logic [CHANNELS*2-1:0] ref_select_wdata
);
    initial {reg_addr, reg_wr, reg_wdata, ref_select_wdata, ref_select_wr} = '0;
    // Read data is registered, so it is taken one full cycle after the address.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk) reg_addr = a;
        @(negedge clk) d = reg_rdata;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge clk) reg_wr = 0;
    endtask
    task automatic sel(input logic [CHANNELS*2-1:0] v);
        @(negedge clk) {ref_select_wdata, ref_select_wr} = {v, 1'b1};
        @(negedge clk) ref_select_wr = 0;
    endtask
endmodule

// file: bench/dac_lock_status_and_ref_select_tb_top.sv
// Self-checking bench for the lock status and reference select block.
`timescale 1ns/10ps
module dac_lock_status_and_ref_select_tb_top;
    import dac_ctl_pkg::*;
    logic clk = 0, arst_n = 0, reg_wr, reg_hit, ref_select_wr;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, got;
    logic [3:0] code_freeze_flag = 4'hC, setup_freeze_flag = 4'hA, chan_power_down = 4'h0;
    logic [3:0] sw_supply, sw_bandgap, sw_pin_unbuf, sw_pin_buf;
    logic [7:0] nv_ref_source_select = 8'h1B, ref_select_wdata, ref_source_select;
    logic [31:0] dac_code = 32'h0, ladder_tap;
    wire [15:0] sw = {sw_pin_buf, sw_pin_unbuf, sw_bandgap, sw_supply};
    int bad_count = 0, cmp_count = 0;
    initial forever #50 clk = ~clk;
    dac_lock_status_and_ref_select #(.CHANNELS(4), .RES_BITS(8)) i_dut (.*);
    dac_host_model #(.CHANNELS(4)) i_host (.*);
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1;
        repeat (6) @(negedge clk);
        code_freeze_flag = 4'h3;
        i_host.rd(ADDR_LOCK_SUMMARY, got);
        chk("lock", 32'h00E4, got);
        chk("sel", 32'h1B, ref_source_select);
        chk("sw", 32'h1248, sw);
        $display("test recall done");
        i_host.wr(ADDR_LOCK_SUMMARY, 16'hFFFF);
        i_host.rd(ADDR_LOCK_SUMMARY, got);
        chk("lock_wr", 32'h00E4, got);
        chk("hit", 32'h1, reg_hit);
        i_host.rd(5'h00, got);
        chk("unmapped", 32'h0, got);
        chk("no_hit", 32'h0, reg_hit);
        $display("test read only done");
        i_host.sel(8'h00);
        repeat (2) @(negedge clk);
        chk("sel_wr", 32'h0, ref_source_select);
        chk("sw_supply", 32'h000F, sw);
        dac_code = 32'hFF00_7F01;
        chan_power_down = 4'hF;
        repeat (3) @(negedge clk);
        chk("tap", 32'hFF00_7F01, ladder_tap);
        chk("pd_sw", 32'h0, sw);
        $display("test ladder done");
        close_out();
    end
    initial begin
        repeat (200) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule

// file: bench/dac_ref_checker.sv
// Assertion checker for the lock status and reference select block.
`timescale 1ns/10ps
module dac_ref_checker import dac_ctl_pkg::*; #(parameter int CHANNELS = 8, RES_BITS = 12) (
    input logic clk, arst_n, reg_hit,
    input logic [REG_ADDR_W-1:0] reg_addr,
    input logic [LOCK_REG_W-1:0] reg_rdata,
    input logic [CHANNELS*RES_BITS-1:0] dac_code, ladder_tap,
    input logic [CHANNELS-1:0] chan_power_down, sw_supply, sw_bandgap, sw_pin_unbuf, sw_pin_buf,
    input logic [CHANNELS*2-1:0] ref_source_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire [3:0] sw0 = {sw_pin_buf[0], sw_pin_unbuf[0], sw_bandgap[0], sw_supply[0]};
    AST_HIT: assert property (reg_hit == (reg_addr == ADDR_LOCK_SUMMARY)) else $error("hit");
    AST_UNMAPPED: assert property (reg_addr != ADDR_LOCK_SUMMARY |=> reg_rdata == 16'h0000) else $error("unmap");
    AST_UPPER: assert property ((reg_rdata >> (2*CHANNELS)) == 0) else $error("upper");
    AST_ONEHOT: assert property ($onehot0(sw0)) else $error("onehot");
    AST_PD: assert property (chan_power_down[0] [*3] |-> sw0 == 4'h0) else $error("pd");
    AST_PDALL: assert property (((sw_supply | sw_bandgap | sw_pin_unbuf | sw_pin_buf) & chan_power_down
        & $past(chan_power_down) & $past(chan_power_down, 2)) == 0) else $error("pd all");
    AST_SEL: assert property ((!chan_power_down[0] && $stable(ref_source_select[1:0])) [*3]
        |-> sw0 == 4'h1 << ref_source_select[1:0]) else $error("sel");
    AST_TAP: assert property ($stable(dac_code) [*2] |-> ladder_tap == dac_code) else $error("tap");
endmodule
bind dac_lock_status_and_ref_select dac_ref_checker #(.CHANNELS(CHANNELS), .RES_BITS(RES_BITS)) i_chk (.*);

// file: core/dac_lock_status_and_ref_select.sv
// Lock status register, ladder tap decode and reference selection for the converter.
//
// Summary of operation
// - Two lock bits per channel in status register.
// - Lock field encodes code and setup locks.
// - Quad part reads upper byte as zero.
// - Lock status loads from nonvolatile bits after reset.
// - Volatile code selects the ladder tap.
// - Highest tap is element count minus one.
// - Powered-down channel disconnects from its reference.
// - Two-bit select routes one of four references.
// - Reset copies nonvolatile select into volatile select.
// - Supply source keeps reference pin disconnected.
//
// The block sits between the serial register logic and the analog ladder. It keeps the
// read-only lock summary, the volatile reference select and the tap and switch controls.
// Everything that reaches the analog side comes from a flip-flop, so the ladder switches
// never see decode glitches.
`timescale 1ns/10ps

module dac_lock_status_and_ref_select #(
    parameter int CHANNELS = 8,
    parameter int RES_BITS = 12
) (
    // Clock and reset.
    input  wire logic                                       clk,
    input  wire logic                                       arst_n,
    // Register access from the serial interface logic.
    input  wire logic [dac_ctl_pkg::REG_ADDR_W-1:0]         reg_addr,
    input  wire logic                                       reg_wr,
    input  wire logic [dac_ctl_pkg::LOCK_REG_W-1:0]         reg_wdata,
    output logic      [dac_ctl_pkg::LOCK_REG_W-1:0]         reg_rdata,
    output logic                                            reg_hit,
    // Nonvolatile configuration bits, stable after power-on.
    input  wire logic [CHANNELS-1:0]                        code_freeze_flag,
    input  wire logic [CHANNELS-1:0]                        setup_freeze_flag,
    input  wire logic [CHANNELS*dac_ctl_pkg::REF_SEL_W-1:0] nv_ref_source_select,
    // Volatile per-channel settings.
    input  wire logic [CHANNELS*RES_BITS-1:0]               dac_code,
    input  wire logic [CHANNELS*dac_ctl_pkg::REF_SEL_W-1:0] ref_select_wdata,
    input  wire logic                                       ref_select_wr,
    input  wire logic [CHANNELS-1:0]                        chan_power_down,
    // Ladder controls.
    output logic      [CHANNELS*RES_BITS-1:0]               ladder_tap,
    output logic      [CHANNELS-1:0]                        sw_supply,
    output logic      [CHANNELS-1:0]                        sw_bandgap,
    output logic      [CHANNELS-1:0]                        sw_pin_unbuf,
    output logic      [CHANNELS-1:0]                        sw_pin_buf,
    output logic      [CHANNELS*dac_ctl_pkg::REF_SEL_W-1:0] ref_source_select
);
    import dac_ctl_pkg::*;

    // Widths of the packed per-channel buses.
    localparam int LOCK_USED_W = CHANNELS * LOCK_FIELD_W;
    localparam int SEL_BUS_W   = CHANNELS * REF_SEL_W;
    localparam int TAP_BUS_W   = CHANNELS * RES_BITS;

    // Parameter checks refuse sizes that the field packing and tap decode cannot serve.
    if (CHANNELS != CHAN_OCTAL && CHANNELS != CHAN_QUAD) begin : g_bad_channels
        $error("CHANNELS must be 4 or 8.");
    end
    if (RES_BITS != RES_BITS_LOW && RES_BITS != RES_BITS_MID && RES_BITS != RES_BITS_HIGH) begin : g_bad_res
        $error("RES_BITS must be 8, 10 or 12.");
    end
    if (LOCK_USED_W > LOCK_REG_W) begin : g_bad_lock_width
        $error("Lock fields do not fit in the status register.");
    end

    // Packs one channel's lock field. The code lock is the upper bit, so a code lock alone
    // reads as binary 10 and a setup lock alone as 01.
    function automatic logic [LOCK_FIELD_W-1:0] lock_field(
        input logic code_lock,
        input logic setup_lock
    );
        logic [LOCK_FIELD_W-1:0] f;
        f                 = '0;
        f[LOCK_CODE_POS]  = code_lock;
        f[LOCK_SETUP_POS] = setup_lock;
        return f;
    endfunction

    // Extracts one channel's reference select from the packed select bus.
    function automatic ref_src_e sel_of(
        input logic [SEL_BUS_W-1:0] bus,
        input int                   chan
    );
        return ref_src_e'(bus[chan*REF_SEL_W +: REF_SEL_W]);
    endfunction

    // Every switch control goes through this one decode, so no two sources can be closed onto
    // one ladder at the same time, and a powered-down channel opens all of them.
    function automatic logic route_on(
        input logic     powered_down,
        input ref_src_e chosen,
        input ref_src_e source
    );
        return !powered_down && (chosen == source);
    endfunction

    // The code field is exactly RES_BITS wide, so its largest value is the element count minus
    // one and a full-scale code still leaves one element between the tap and the reference.
    function automatic logic [RES_BITS-1:0] tap_of(
        input logic [TAP_BUS_W-1:0] bus,
        input int                   chan
    );
        return bus[chan*RES_BITS +: RES_BITS];
    endfunction

    // Only the lock summary is mapped here; any other address reads as zero.
    function automatic logic [LOCK_REG_W-1:0] read_mux(
        input logic [REG_ADDR_W-1:0] addr,
        input logic [LOCK_REG_W-1:0] lock_word
    );
        logic [LOCK_REG_W-1:0] word;
        word = '0;
        if (addr == ADDR_LOCK_SUMMARY)
            word = lock_word;
        return word;
    endfunction

    // The nonvolatile bits come from storage that is not timed to this clock, so each level
    // passes two flip-flops first. Only the second stage is read by any logic.
    logic [CHANNELS-1:0]  code_s1_r;
    logic [CHANNELS-1:0]  code_s2_r;
    logic [CHANNELS-1:0]  setup_s1_r;
    logic [CHANNELS-1:0]  setup_s2_r;
    logic [SEL_BUS_W-1:0] nvref_s1_r;
    logic [SEL_BUS_W-1:0] nvref_s2_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_s1_r <= '0;
            code_s2_r <= '0;
        end else begin
            code_s1_r <= code_freeze_flag;
            code_s2_r <= code_s1_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_s1_r <= '0;
            setup_s2_r <= '0;
        end else begin
            setup_s1_r <= setup_freeze_flag;
            setup_s2_r <= setup_s1_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nvref_s1_r <= '0;
            nvref_s2_r <= '0;
        end else begin
            nvref_s1_r <= nv_ref_source_select;
            nvref_s2_r <= nvref_s1_r;
        end
    end

    // Recall runs once after each reset release. The counter gives the synchroniser time to
    // fill, so the first values taken are the stored ones and not the reset zeros.
    logic [RECALL_CNT_W-1:0] load_cnt_r;
    logic                    loaded_r;
    logic                    recall;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            load_cnt_r <= '0;
        else if (!loaded_r)
            load_cnt_r <= load_cnt_r + RECALL_STEP;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            loaded_r <= 1'b0;
        else if (recall)
            loaded_r <= 1'b1;
    end

    assign recall = !loaded_r && (load_cnt_r == RECALL_AT);

    // Lock status register. Fields above the last channel stay zero on the quad part.
    // Limitation: the summary is taken once per reset, so a later change of the stored
    // lock bits shows only after the next reset.
    logic [LOCK_REG_W-1:0] lock_state_summary_r;
    logic [LOCK_REG_W-1:0] lock_state_summary_nxt;
    logic                  lock_wr_attempt;

    always_comb begin
        lock_state_summary_nxt = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            lock_state_summary_nxt[c*LOCK_FIELD_W +: LOCK_FIELD_W] =
                lock_field(code_s2_r[c], setup_s2_r[c]);
        end
    end

    // A host write to the summary is seen but its data goes nowhere; every bit is read-only.
    assign lock_wr_attempt = reg_wr && reg_hit;

    // A recall overrides a write attempt that falls in the same cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            lock_state_summary_r <= LOCK_RESET_VALUE;
        else if (recall)
            lock_state_summary_r <= lock_state_summary_nxt;
        else if (lock_wr_attempt)
            lock_state_summary_r <= lock_state_summary_r;
    end

    // Write data has no destination in this block.
    logic [LOCK_REG_W-1:0] unused_wdata;
    assign unused_wdata = reg_wdata;

    // Hit is combinational so the serial logic can decide its acknowledge in the same cycle.
    assign reg_hit = (reg_addr == ADDR_LOCK_SUMMARY);

    // Read data is registered, so it answers one cycle after the address is presented.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= '0;
        else
            reg_rdata <= read_mux(reg_addr, lock_state_summary_r);
    end

    // Host select writes are dropped until the recall is done, so a write that arrives
    // early can never be replaced by the stored value a few cycles later.
    logic                 sel_wr_ok;
    logic [SEL_BUS_W-1:0] vref_r;
    logic [SEL_BUS_W-1:0] vref_nxt;

    assign sel_wr_ok = ref_select_wr && loaded_r;

    always_comb begin
        vref_nxt = vref_r;
        if (recall)
            vref_nxt = nvref_s2_r;
        else if (sel_wr_ok)
            vref_nxt = ref_select_wdata;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            vref_r <= '0;
        else
            vref_r <= vref_nxt;
    end

    assign ref_source_select = vref_r;

    // Tap positions follow the volatile codes one cycle later.
    logic [TAP_BUS_W-1:0] ladder_tap_nxt;

    always_comb begin
        ladder_tap_nxt = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            ladder_tap_nxt[c*RES_BITS +: RES_BITS] = tap_of(dac_code, c);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ladder_tap <= '0;
        else
            ladder_tap <= ladder_tap_nxt;
    end

    // Reference switch controls, one per source and channel. Supply mode closes only the
    // supply switch, so the reference pin stays off the ladder. Registering the switches
    // costs one cycle after a select write, which is traded for clean switching.
    logic [CHANNELS-1:0] sw_supply_nxt;
    logic [CHANNELS-1:0] sw_bandgap_nxt;
    logic [CHANNELS-1:0] sw_pin_unbuf_nxt;
    logic [CHANNELS-1:0] sw_pin_buf_nxt;

    always_comb begin
        sw_supply_nxt    = '0;
        sw_bandgap_nxt   = '0;
        sw_pin_unbuf_nxt = '0;
        sw_pin_buf_nxt   = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            sw_supply_nxt[c]    = route_on(chan_power_down[c], sel_of(vref_r, c), REF_SUPPLY);
            sw_bandgap_nxt[c]   = route_on(chan_power_down[c], sel_of(vref_r, c), REF_BANDGAP);
            sw_pin_unbuf_nxt[c] = route_on(chan_power_down[c], sel_of(vref_r, c), REF_PIN_UNBUF);
            sw_pin_buf_nxt[c]   = route_on(chan_power_down[c], sel_of(vref_r, c), REF_PIN_BUF);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_supply    <= '0;
            sw_bandgap   <= '0;
            sw_pin_unbuf <= '0;
            sw_pin_buf   <= '0;
        end else begin
            sw_supply    <= sw_supply_nxt;
            sw_bandgap   <= sw_bandgap_nxt;
            sw_pin_unbuf <= sw_pin_unbuf_nxt;
            sw_pin_buf   <= sw_pin_buf_nxt;
        end
    end
endmodule

// file: pkg/dac_ctl_pkg.sv
// Constants and types shared by the converter control block.
package dac_ctl_pkg;
    localparam int          REG_ADDR_W         = 5;
    localparam logic [4:0]  ADDR_LOCK_SUMMARY  = 5'h0B;
    localparam int          LOCK_REG_W         = 16;
    localparam int          LOCK_FIELD_W       = 2;
    localparam int          REF_SEL_W          = 2;
    localparam int          CHAN_OCTAL         = 8;
    localparam int          CHAN_QUAD          = 4;
    localparam logic [15:0] LOCK_RESET_VALUE   = 16'h0000;
    localparam logic [1:0]  LOCK_NONE          = 2'h0;
    localparam logic [1:0]  LOCK_NV_ONLY       = 2'h1;
    localparam logic [1:0]  LOCK_CODE_ALL      = 2'h2;
    localparam logic [1:0]  LOCK_ALL           = 2'h3;
    localparam int          LOCK_CODE_POS      = 1;
    localparam int          LOCK_SETUP_POS     = 0;
    localparam int          RES_BITS_LOW       = 8;
    localparam int          RES_BITS_MID       = 10;
    localparam int          RES_BITS_HIGH      = 12;
    localparam int          RECALL_CNT_W       = 2;
    localparam logic [1:0]  RECALL_AT          = 2'h2;
    localparam logic [1:0]  RECALL_STEP        = 2'h1;

    typedef enum logic [1:0] {
        REF_SUPPLY,
        REF_BANDGAP,
        REF_PIN_UNBUF,
        REF_PIN_BUF
    } ref_src_e;
endpackage
